// File: cpab_pkg.sv
// Constants, opcodes and decode types for the channel program add/and/branch unit.
// Assumes a single 20 MHz clock and a synchronous active-low reset at the user.
//
// Overview of operation
// - 0x58 adds table entry into accumulator.
// - 0x78 adds table entry into index.
// - 0x88 adds index-selected entry into accumulator.
// - 0x98 adds immediate byte into accumulator.
// - 0xB8 adds immediate byte into index.
// - Adds set carry, sign and zero flags.
// - 0x53 ands table entry into accumulator.
// - 0x73 ands table entry into index.
// - 0x83 ands index-selected entry into accumulator.
// - 0x93 ands immediate byte into accumulator.
// - 0xB3 ands immediate byte into index.
// - Ands update only sign and zero flags.
// - 0xE0 adds signed displacement to counter plus one.
// - 0xF0 saves low byte of counter plus two, then branches.
// - Table index is unsigned byte 0..255.
`default_nettype none
package cpab_pkg;

  localparam int          DATA_W        = 8;
  localparam int          PC_W          = 16;
  localparam int          LCT_DEPTH     = 256;
  localparam logic [7:0]  OP_ADD_T_ACC  = 8'h58;
  localparam logic [7:0]  OP_ADD_T_IDX  = 8'h78;
  localparam logic [7:0]  OP_ADD_I_ACC  = 8'h88;
  localparam logic [7:0]  OP_ADD_M_ACC  = 8'h98;
  localparam logic [7:0]  OP_ADD_M_IDX  = 8'hB8;
  localparam logic [7:0]  OP_AND_T_ACC  = 8'h53;
  localparam logic [7:0]  OP_AND_T_IDX  = 8'h73;
  localparam logic [7:0]  OP_AND_I_ACC  = 8'h83;
  localparam logic [7:0]  OP_AND_M_ACC  = 8'h93;
  localparam logic [7:0]  OP_AND_M_IDX  = 8'hB3;
  localparam logic [7:0]  OP_BRANCH     = 8'hE0;
  localparam logic [7:0]  OP_CALL       = 8'hF0;
  localparam logic [7:0]  LINK_ENTRY    = 8'h12;
  localparam logic [7:0]  RST_REG       = 8'h00;
  localparam logic [15:0] RST_PC        = 16'h0000;

  typedef enum logic [1:0] {
    CPAB_SRC_TABLE,
    CPAB_SRC_INDEXED,
    CPAB_SRC_IMM
  } cpab_src_t;

endpackage
`default_nettype wire

// File: cpab_alu.sv
// Byte adder/masker with flag generation.
// Purely combinational; the caller latches result and flags.
`timescale 1ns/10ps
`default_nettype none
module cpab_alu (
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       do_and,
  output logic      [7:0] res,
  output logic            carry,
  output logic            sign,
  output logic            zero
);
  wire logic [8:0] sum_w;

  assign sum_w = {1'b0, a} + {1'b0, b};
  assign res   = do_and ? (a & b) : sum_w[7:0];
  assign carry = do_and ? 1'b0 : sum_w[8];
  assign sign  = res[7];
  assign zero  = (res == 8'h00);
endmodule
`default_nettype wire

// File: cpab_core.sv
// Execution unit for add, and, branch and call of the channel program.
// Assumes instruction bytes arrive one per cycle with a valid strobe, in order.
`timescale 1ns/10ps
`default_nettype none
module cpab_core (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_in,
  output logic             byte_ready,
  output logic [7:0]       acc_q,
  output logic [7:0]       index_q,
  output logic [15:0]      pc_q,
  output logic             carry_flag_q,
  output logic             sign_flag_q,
  output logic             zero_flag_q,
  output logic             done_q,
  output logic             illegal_q,
  input  wire logic [7:0]  tbl_rd_addr,
  output logic [7:0]       tbl_rd_data
);

  // --------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------
  typedef enum logic {CPAB_FETCH, CPAB_OPERAND} cpab_state_t;

  cpab_state_t state_q;
  logic [7:0]  op_q;
  logic [7:0]  tbl_q [cpab_pkg::LCT_DEPTH];

  wire logic is_add_t_acc = byte_in == cpab_pkg::OP_ADD_T_ACC;
  wire logic is_add_t_idx = byte_in == cpab_pkg::OP_ADD_T_IDX;
  wire logic is_add_i_acc = byte_in == cpab_pkg::OP_ADD_I_ACC;
  wire logic is_add_m_acc = byte_in == cpab_pkg::OP_ADD_M_ACC;
  wire logic is_add_m_idx = byte_in == cpab_pkg::OP_ADD_M_IDX;
  wire logic is_and_t_acc = byte_in == cpab_pkg::OP_AND_T_ACC;
  wire logic is_and_t_idx = byte_in == cpab_pkg::OP_AND_T_IDX;
  wire logic is_and_i_acc = byte_in == cpab_pkg::OP_AND_I_ACC;
  wire logic is_and_m_acc = byte_in == cpab_pkg::OP_AND_M_ACC;
  wire logic is_and_m_idx = byte_in == cpab_pkg::OP_AND_M_IDX;
  wire logic is_branch    = byte_in == cpab_pkg::OP_BRANCH;
  wire logic is_call      = byte_in == cpab_pkg::OP_CALL;

  // Single-byte forms execute at fetch; only two-byte forms wait
  wire logic one_byte  = is_add_i_acc | is_and_i_acc;
  wire logic two_byte  = is_add_t_acc | is_add_t_idx | is_add_m_acc | is_add_m_idx |
                         is_and_t_acc | is_and_t_idx | is_and_m_acc | is_and_m_idx |
                         is_branch | is_call;
  wire logic fetch_go  = byte_valid && state_q == CPAB_FETCH;
  wire logic oper_go   = byte_valid && state_q == CPAB_OPERAND;

  // Opcode bits: low nibble 8 = add, 3 = and; high nibble picks form
  wire logic op_is_and = op_q[3:0] == cpab_pkg::OP_AND_T_ACC[3:0];
  wire logic op_is_alu = op_q != cpab_pkg::OP_BRANCH && op_q != cpab_pkg::OP_CALL;
  wire logic op_to_idx = op_q == cpab_pkg::OP_ADD_T_IDX || op_q == cpab_pkg::OP_ADD_M_IDX ||
                         op_q == cpab_pkg::OP_AND_T_IDX || op_q == cpab_pkg::OP_AND_M_IDX;
  wire logic op_imm    = op_q == cpab_pkg::OP_ADD_M_ACC || op_q == cpab_pkg::OP_ADD_M_IDX ||
                         op_q == cpab_pkg::OP_AND_M_ACC || op_q == cpab_pkg::OP_AND_M_IDX;

  // --------------------------------------------------------------------
  // Operand selection
  // --------------------------------------------------------------------
  wire logic [7:0] tbl_by_byte  = tbl_q[byte_in];
  wire logic [7:0] tbl_by_index = tbl_q[index_q];
  wire logic [7:0] oper_b       = op_imm ? byte_in : tbl_by_byte;
  wire logic [7:0] oper_a       = op_to_idx ? index_q : acc_q;

  wire logic [7:0] alu_a        = fetch_go ? acc_q : oper_a;
  wire logic [7:0] alu_b        = fetch_go ? tbl_by_index : oper_b;
  wire logic       alu_and      = fetch_go ? is_and_i_acc : op_is_and;

  logic [7:0] alu_res;
  logic       alu_c;
  logic       alu_s;
  logic       alu_z;

  cpab_alu u_alu (
    .a      (alu_a),
    .b      (alu_b),
    .do_and (alu_and),
    .res    (alu_res),
    .carry  (alu_c),
    .sign   (alu_s),
    .zero   (alu_z)
  );

  // Counter arithmetic; displacement is relative to the operand byte
  wire logic [15:0] pc_plus1  = pc_q + 16'h0001;
  wire logic [15:0] pc_plus2  = pc_q + 16'h0002;
  wire logic [15:0] pc_disp   = pc_plus1 + {{8{byte_in[7]}}, byte_in};
  wire logic        do_jump   = oper_go && !op_is_alu;
  wire logic        do_alu_op = oper_go && op_is_alu;
  wire logic        do_alu_1b = fetch_go && one_byte;
  wire logic        acc_wr    = do_alu_1b || (do_alu_op && !op_to_idx);
  wire logic        idx_wr    = do_alu_op && op_to_idx;

  assign byte_ready  = 1'b1;
  assign tbl_rd_data = tbl_q[tbl_rd_addr];

  // --------------------------------------------------------------------
  // Sequencing
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_q   <= CPAB_FETCH;
      op_q      <= cpab_pkg::RST_REG;
      illegal_q <= 1'b0;
      done_q    <= 1'b0;
    end else begin
      done_q    <= do_alu_1b || oper_go;
      illegal_q <= fetch_go && !one_byte && !two_byte;
      unique case (state_q)
        CPAB_FETCH: begin
          if (byte_valid && two_byte) begin
            state_q <= CPAB_OPERAND;
            op_q    <= byte_in;
          end
        end
        CPAB_OPERAND: begin
          if (byte_valid) begin
            state_q <= CPAB_FETCH;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      acc_q        <= cpab_pkg::RST_REG;
      index_q      <= cpab_pkg::RST_REG;
      carry_flag_q <= 1'b0;
      sign_flag_q  <= 1'b0;
      zero_flag_q  <= 1'b0;
    end else if (acc_wr || idx_wr) begin
      if (acc_wr) begin
        acc_q <= alu_res;
      end
      if (idx_wr) begin
        index_q <= alu_res;
      end
      if (!alu_and) begin
        carry_flag_q <= alu_c;
      end
      sign_flag_q <= alu_s;
      zero_flag_q <= alu_z;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pc_q <= cpab_pkg::RST_PC;
    end else if (do_alu_1b || (fetch_go && !two_byte)) begin
      pc_q <= pc_plus1;
    end else if (do_alu_op) begin
      pc_q <= pc_plus2;
    end else if (do_jump) begin
      pc_q <= pc_disp;
    end
  end

  // Table has no reset: it models working storage, not control state
  always_ff @(posedge clk_sys) begin
    if (resetn && do_jump && op_q == cpab_pkg::OP_CALL) begin
      // Link points past the operand, so a return resumes after the call
      tbl_q[cpab_pkg::LINK_ENTRY] <= pc_plus2[7:0];
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  AST_ADD_ACC: assert property (@(posedge clk_sys) disable iff (!resetn)
    (oper_go && op_q == cpab_pkg::OP_ADD_M_ACC) |=>
      acc_q == 8'($past(acc_q) + $past(byte_in)))
    else $error("Immediate add to accumulator wrong");
  AST_ADD_IDX: assert property (@(posedge clk_sys) disable iff (!resetn)
    (oper_go && op_q == cpab_pkg::OP_ADD_M_IDX) |=>
      index_q == 8'($past(index_q) + $past(byte_in)) && acc_q == $past(acc_q))
    else $error("Immediate add to index wrong");
  AST_CARRY: assert property (@(posedge clk_sys) disable iff (!resetn)
    (oper_go && op_q == cpab_pkg::OP_ADD_M_ACC) |=>
      carry_flag_q == ({1'b0, $past(acc_q)} + {1'b0, $past(byte_in)} > 9'h0FF))
    else $error("Carry flag wrong after add");
  AST_AND_ACC: assert property (@(posedge clk_sys) disable iff (!resetn)
    (oper_go && op_q == cpab_pkg::OP_AND_M_ACC) |=>
      acc_q == ($past(acc_q) & $past(byte_in)))
    else $error("Immediate and to accumulator wrong");
  AST_AND_CARRY: assert property (@(posedge clk_sys) disable iff (!resetn)
    (oper_go && op_is_alu && op_is_and) |=>
      carry_flag_q == $past(carry_flag_q) &&
      zero_flag_q == (($past(op_to_idx) ? index_q : acc_q) == 8'h00))
    else $error("And disturbed carry or zero");
  AST_SIGN: assert property (@(posedge clk_sys) disable iff (!resetn)
    (do_alu_1b) |=> sign_flag_q == acc_q[7] && zero_flag_q == (acc_q == 8'h00))
    else $error("Sign or zero flag mismatch");
  AST_BRANCH: assert property (@(posedge clk_sys) disable iff (!resetn)
    (oper_go && op_q == cpab_pkg::OP_BRANCH) |=>
      pc_q == 16'($past(pc_q) + 16'h0001 + {{8{$past(byte_in[7])}}, $past(byte_in)}) &&
      $stable(sign_flag_q))
    else $error("Branch target wrong");
  AST_CALL: assert property (@(posedge clk_sys) disable iff (!resetn)
    (oper_go && op_q == cpab_pkg::OP_CALL) |=>
      tbl_q[cpab_pkg::LINK_ENTRY] == 8'($past(pc_q) + 16'h0002))
    else $error("Call link not saved");
  AST_STEP2: assert property (@(posedge clk_sys) disable iff (!resetn)
    (oper_go && op_is_alu) |=> pc_q == 16'($past(pc_q) + 16'h0002))
    else $error("Two-byte step wrong");
  AST_STEP1: assert property (@(posedge clk_sys) disable iff (!resetn)
    (do_alu_1b) |=> pc_q == 16'($past(pc_q) + 16'h0001) && state_q == CPAB_FETCH)
    else $error("One-byte step wrong");

  // --------------------------------------------------------------------
  // Operand and flag checks
  // --------------------------------------------------------------------
  AST_ADD_TBL_ACC: assert property (@(posedge clk_sys) disable iff (!resetn)
    (oper_go && op_q == cpab_pkg::OP_ADD_T_ACC) |=>
      acc_q == 8'($past(acc_q) + $past(tbl_by_byte)))
    else $error("Table add to accumulator wrong");
  AST_ADD_TBL_IDX: assert property (@(posedge clk_sys) disable iff (!resetn)
    (oper_go && op_q == cpab_pkg::OP_ADD_T_IDX) |=>
      index_q == 8'($past(index_q) + $past(tbl_by_byte)) && $stable(acc_q))
    else $error("Table add to index wrong");
  AST_ADD_IND_ACC: assert property (@(posedge clk_sys) disable iff (!resetn)
    (fetch_go && is_add_i_acc) |=>
      acc_q == 8'($past(acc_q) + $past(tbl_by_index)))
    else $error("Indexed add to accumulator wrong");
  AST_AND_TBL_ACC: assert property (@(posedge clk_sys) disable iff (!resetn)
    (oper_go && op_q == cpab_pkg::OP_AND_T_ACC) |=>
      acc_q == ($past(acc_q) & $past(tbl_by_byte)))
    else $error("Table and to accumulator wrong");
  AST_AND_TBL_IDX: assert property (@(posedge clk_sys) disable iff (!resetn)
    (oper_go && op_q == cpab_pkg::OP_AND_T_IDX) |=>
      index_q == ($past(index_q) & $past(tbl_by_byte)) && $stable(acc_q))
    else $error("Table and to index wrong");
  AST_AND_IND_ACC: assert property (@(posedge clk_sys) disable iff (!resetn)
    (fetch_go && is_and_i_acc) |=>
      acc_q == ($past(acc_q) & $past(tbl_by_index)))
    else $error("Indexed and to accumulator wrong");
  AST_AND_IDX: assert property (@(posedge clk_sys) disable iff (!resetn)
    (oper_go && op_q == cpab_pkg::OP_AND_M_IDX) |=>
      index_q == ($past(index_q) & $past(byte_in)) && $stable(acc_q))
    else $error("Immediate and to index wrong");
  AST_ACC_FLAGS: assert property (@(posedge clk_sys) disable iff (!resetn)
    (acc_wr) |=>
      sign_flag_q == acc_q[7] && zero_flag_q == (acc_q == 8'h00))
    else $error("Accumulator sign or zero flag wrong");
  AST_IDX_FLAGS: assert property (@(posedge clk_sys) disable iff (!resetn)
    (idx_wr) |=>
      sign_flag_q == index_q[7] && zero_flag_q == (index_q == 8'h00))
    else $error("Index sign or zero flag wrong");
  AST_IDX_CARRY: assert property (@(posedge clk_sys) disable iff (!resetn)
    (oper_go && op_q == cpab_pkg::OP_ADD_M_IDX) |=>
      carry_flag_q == ({1'b0, $past(index_q)} + {1'b0, $past(byte_in)} > 9'h0FF))
    else $error("Carry flag wrong after index add");
  AST_TBL_CARRY: assert property (@(posedge clk_sys) disable iff (!resetn)
    (oper_go && op_q == cpab_pkg::OP_ADD_T_ACC) |=>
      carry_flag_q == ({1'b0, $past(acc_q)} + {1'b0, $past(tbl_by_byte)} > 9'h0FF))
    else $error("Carry flag wrong after table add");
  AST_TBL_IDX_CARRY: assert property (@(posedge clk_sys) disable iff (!resetn)
    (oper_go && op_q == cpab_pkg::OP_ADD_T_IDX) |=>
      carry_flag_q == ({1'b0, $past(index_q)} + {1'b0, $past(tbl_by_byte)} > 9'h0FF))
    else $error("Carry flag wrong after table add to index");
  AST_IND_CARRY: assert property (@(posedge clk_sys) disable iff (!resetn)
    (fetch_go && is_add_i_acc) |=>
      carry_flag_q == ({1'b0, $past(acc_q)} + {1'b0, $past(tbl_by_index)} > 9'h0FF))
    else $error("Carry flag wrong after indexed add");
  AST_AND1_KEEP: assert property (@(posedge clk_sys) disable iff (!resetn)
    (fetch_go && is_and_i_acc) |=>
      $stable(carry_flag_q) && $stable(index_q))
    else $error("Indexed and disturbed carry or index");
  AST_BRANCH_KEEP: assert property (@(posedge clk_sys) disable iff (!resetn)
    (oper_go && !op_is_alu) |=>
      $stable(carry_flag_q) && $stable(zero_flag_q) && $stable(acc_q) && $stable(index_q))
    else $error("Branch disturbed flags or registers");
  AST_CALL_PC: assert property (@(posedge clk_sys) disable iff (!resetn)
    (oper_go && op_q == cpab_pkg::OP_CALL) |=>
      pc_q == 16'($past(pc_q) + 16'h0001 + {{8{$past(byte_in[7])}}, $past(byte_in)}))
    else $error("Call target wrong");
  AST_FLAGS_HOLD: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!acc_wr && !idx_wr) |=>
      $stable(carry_flag_q) && $stable(sign_flag_q) && $stable(zero_flag_q))
    else $error("Flags moved without a register write");
  AST_DONE: assert property (@(posedge clk_sys) disable iff (!resetn)
    (do_alu_1b || oper_go) |=>
      done_q && !illegal_q)
    else $error("Done pulse missing");
  AST_ILLEGAL: assert property (@(posedge clk_sys) disable iff (!resetn)
    (fetch_go && !one_byte && !two_byte) |=>
      illegal_q && !done_q && pc_q == 16'($past(pc_q) + 16'h0001))
    else $error("Unknown opcode not stepped over");
  AST_IDLE_HOLD: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!byte_valid) |=>
      $stable(pc_q) && $stable(acc_q) && $stable(index_q))
    else $error("State moved without a byte");
  AST_OPER_WAIT: assert property (@(posedge clk_sys) disable iff (!resetn)
    (fetch_go && two_byte) |=>
      state_q == CPAB_OPERAND && $stable(pc_q) && $stable(acc_q) && $stable(index_q))
    else $error("Two-byte opcode did not wait for operand");

endmodule
`default_nettype wire

// File: test_channel_program_add_and_branch.sv
// Self-checking testbench for the channel program add/and/branch unit.
// Assumes cpab_pkg and cpab_core are compiled first; drives the byte stream itself.
`timescale 1ns/10ps
`default_nettype none
module test_channel_program_add_and_branch;
  logic        clk_sys;
  logic        resetn;
  logic        byte_valid;
  logic [7:0]  byte_in;
  logic        byte_ready;
  logic [7:0]  acc_q;
  logic [7:0]  index_q;
  logic [15:0] pc_q;
  logic        carry_flag_q;
  logic        sign_flag_q;
  logic        zero_flag_q;
  logic        done_q;
  logic        illegal_q;
  logic [7:0]  tbl_rd_addr;
  logic [7:0]  tbl_rd_data;
  int          error_cnt;
  int          tests_run;
  // Reference state kept beside the design
  logic [7:0]  e_acc, e_idx, t18;
  logic [15:0] e_pc;
  logic        e_c, e_s, e_z;

  cpab_core i_dut (.clk_sys(clk_sys), .resetn(resetn), .byte_valid(byte_valid), .byte_in(byte_in),
    .byte_ready(byte_ready), .acc_q(acc_q), .index_q(index_q), .pc_q(pc_q), .carry_flag_q(carry_flag_q),
    .sign_flag_q(sign_flag_q), .zero_flag_q(zero_flag_q), .done_q(done_q), .illegal_q(illegal_q),
    .tbl_rd_addr(tbl_rd_addr), .tbl_rd_data(tbl_rd_data));

  always #25 clk_sys = ~clk_sys;

  // ----------------------------------------
  // Reporting
  // ----------------------------------------
  task automatic check(input string nm, input logic [19:0] e, input logic [19:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // One instruction, then compare all outputs except the table read port
  // ----------------------------------------
  task automatic exec(input logic [7:0] op, input logic [7:0] opr);
    logic [8:0] sum;
    logic [7:0] a, b, r;
    logic       two, ill, is_and, sel_idx;
    int         n;
    two = 1'b1;
    ill = 1'b0;
    if (op inside {8'h58, 8'h78, 8'h88, 8'h98, 8'hB8, 8'h53, 8'h73, 8'h83, 8'h93, 8'hB3}) begin
      is_and  = op[3:0] == 4'h3;
      sel_idx = op[7:4] == 4'h7 || op[7:4] == 4'hB;
      two     = op[7:4] != 4'h8;
      // Table operands are only ever entry 18, the one entry the call can fill
      b   = (op[7:4] == 4'h9 || op[7:4] == 4'hB) ? opr : t18;
      a   = sel_idx ? e_idx : e_acc;
      sum = {1'b0, a} + {1'b0, b};
      r   = is_and ? (a & b) : sum[7:0];
      if (!is_and) e_c = sum[8];
      e_s = r[7];
      e_z = r == 8'h00;
      if (sel_idx) e_idx = r;
      else e_acc = r;
      e_pc = e_pc + (two ? 16'h0002 : 16'h0001);
    end else if (op == 8'hE0 || op == 8'hF0) begin
      if (op == 8'hF0) t18 = e_pc[7:0] + 8'h02;
      e_pc = e_pc + 16'h0001 + {{8{opr[7]}}, opr};
    end else begin
      two  = 1'b0;
      ill  = 1'b1;
      e_pc = e_pc + 16'h0001;
    end
    @(posedge clk_sys);
    byte_valid <= 1'b1;
    byte_in    <= op;
    if (two) begin
      @(posedge clk_sys);
      byte_in <= opr;
    end
    @(posedge clk_sys);
    byte_valid <= 1'b0;
    byte_in    <= ~opr;
    n = 0;
    #1;
    while (done_q !== 1'b1 && illegal_q !== 1'b1 && n < 4) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (done_q !== 1'b1 && illegal_q !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH done_q expected 1 seen %b", done_q);
      print_verdict();
    end
    check("acc_idx_flags_illegal", {e_acc, e_idx, e_c, e_s, e_z, ill},
          {acc_q, index_q, carry_flag_q, sign_flag_q, zero_flag_q, illegal_q});
    check("pc", {4'h0, e_pc}, {4'h0, pc_q});
    check("done", {19'h0_0000, ~ill}, {19'h0_0000, done_q});
    check("byte_ready", 20'h0_0001, {19'h0_0000, byte_ready});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sc_immediate();
    exec(8'h98, 8'h91);
    exec(8'h98, 8'h69);
    exec(8'hB8, 8'h5B);
    exec(8'hB8, 8'hA5);
    exec(8'h93, 8'h37);
    exec(8'hB8, 8'h72);
    exec(8'hB3, 8'h37);
    exec(8'h93, 8'h00);
  endtask

  task automatic sc_branch();
    exec(8'hE0, 8'h40);
    exec(8'hE0, 8'h80);
    exec(8'hE0, 8'h7F);
  endtask

  task automatic sc_call_and_table();
    exec(8'hF0, 8'hF6);
    check("link_entry", {12'h000, t18}, {12'h000, tbl_rd_data});
    exec(8'hB3, 8'h00);
    exec(8'hB8, 8'h12);
    exec(8'h88, 8'h00);
    exec(8'h83, 8'h00);
    exec(8'h58, 8'h12);
    exec(8'h53, 8'h12);
    exec(8'h73, 8'h12);
    exec(8'h78, 8'h12);
  endtask

  // Mid-run reset: registers clear, the table keeps its link entry
  task automatic sc_reset();
    @(posedge clk_sys);
    resetn     <= 1'b0;
    byte_valid <= 1'b1;
    byte_in    <= 8'h98;
    @(posedge clk_sys);
    byte_valid <= 1'b0;
    @(posedge clk_sys);
    resetn <= 1'b1;
    #1;
    check("reset_state", 20'h0_0000, {acc_q, index_q, carry_flag_q, sign_flag_q, zero_flag_q, illegal_q});
    check("reset_pc", 20'h0_0000, {4'h0, pc_q});
    check("reset_done", 20'h0_0000, {19'h0_0000, done_q});
    {e_acc, e_idx, e_pc, e_c, e_s, e_z} = '0;
    exec(8'h98, 8'h80);
    check("link_kept", {12'h000, t18}, {12'h000, tbl_rd_data});
  endtask

  task automatic sc_unknown_opcode();
    exec(8'h00, 8'h00);
  endtask

  initial begin
    clk_sys     = 1'b0;
    resetn      = 1'b0;
    byte_valid  = 1'b0;
    byte_in     = 8'h00;
    tbl_rd_addr = 8'h12;
    error_cnt   = 0;
    tests_run   = 0;
    {e_acc, e_idx, e_pc, e_c, e_s, e_z} = '0;
    t18 = 'x;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    sc_immediate();
    sc_branch();
    sc_call_and_table();
    sc_reset();
    sc_unknown_opcode();
    print_verdict();
  end
endmodule
`default_nettype wire
